/* rtl/mhs_pkg.sv */
// Package for the modem handshake pin sharing block: function selects, bit positions, carriers.
// Assumes a single 50 MHz system clock domain and no register bus.
package mhs_pkg;
  // Function select codes for the shared input pin.
  localparam logic [1:0] IN_SEL_GRANT = 2'h0;
  localparam logic [1:0] IN_SEL_SELECT7 = 2'h1;
  localparam logic [1:0] IN_SEL_READY = 2'h2;
  // Function select codes for the shared output pins.
  localparam logic [1:0] OUT_SEL_AUX = 2'h0;
  localparam logic [1:0] OUT_SEL_SELECT = 2'h1;
  localparam logic [1:0] OUT_SEL_MODEM = 2'h2;
  // Modem control and status bit positions.
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 2;
  localparam int MSR_DELTA_BIT = 1;
  localparam int MSR_READY_BIT = 5;
  localparam int MSR_WIDTH = 8;
  // Reset levels of the pins and flags.
  localparam logic PIN_IDLE = 1'h1;
  localparam logic FLAG_CLEAR = 1'h0;

  // Pin function selection carried from the modem signal control register.
  typedef struct packed {
    logic [1:0] in_sel;
    logic [1:0] term_sel;
    logic [1:0] req_sel;
  } mhs_sel_s;

  // Values of the other pin functions that share the same package pins.
  typedef struct packed {
    logic aux_bus_request_out;
    logic select_line_six_n;
    logic select_line_seven_n;
    logic select_line_eight_n;
    logic shared_mem_drive_ctl;
  } mhs_alt_s;
endpackage : mhs_pkg

/* rtl/mhs_change_det.sv */
// Change detector for the ready input: sticky change flag cleared by a status read.
// Assumes its input is already synchronous to mclk.
`timescale 1ns/1ps
module mhs_change_det (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic level_in,
  input wire logic read_clr,
  output logic last_level,
  output logic changed
);
  logic edge_seen;

  // A change is any difference from the last sampled level.
  assign edge_seen = level_in ^ last_level;

  // Set beats clear so a change in the read cycle is kept.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_level <= mhs_pkg::PIN_IDLE;
      changed <= mhs_pkg::FLAG_CLEAR;
    end else begin
      last_level <= level_in;
      changed <= edge_seen | (changed & ~read_clr);
    end
  end

  // RULE4 change flag set.
  a_change_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
    edge_seen |=> changed) else $error("change flag not set");
  // RULE12 read clears flag.
  a_read_clears_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
    (read_clr && !edge_seen) |=> !changed) else $error("read did not clear flag");
endmodule : mhs_change_det

/* rtl/mhs_top.sv */
// Modem handshake pin sharing: shared ready input, terminal ready and send request outputs.
// Assumes synchronous pin inputs and control bits presented as plain ports.
//
// Overview of operation
// RULE1 - Shared input acts as ready input or drives active-low select line seven.
// RULE2 - Modem drives ready line low when ready to link, high otherwise.
// RULE3 - Status bit 5 reads as complement of the ready input level.
// RULE4 - Status bit 1 sets when ready input changed since last status read.
// RULE5 - Each ready status change raises interrupt when modem status interrupt enabled.
// RULE6 - Shared output carries drive control, select line eight or terminal ready.
// RULE7 - Control bit 0 written one drives terminal ready output low.
// RULE8 - Master reset forces terminal ready output inactive high.
// RULE9 - Loopback mode holds terminal ready pin high regardless of control bit.
// RULE10 - Control bit 2 drives send request low; reset and loopback hold it high.
// RULE11 - Auxiliary processor drives active-low bus grant on the shared input pin.
// RULE12 - Reading the modem status register clears the ready change flag.
// RULE13 - Modem status interrupt holds until status read, unless a new change.
`timescale 1ns/1ps
module mhs_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire mhs_pkg::mhs_sel_s pin_sel,
  input wire mhs_pkg::mhs_alt_s alt_out,
  input wire logic ctl_term_ready,
  input wire logic ctl_send_request,
  input wire logic loop_mode,
  input wire logic status_irq_en,
  input wire logic status_read,
  input wire logic ready_pin_in,
  output logic ready_pin_out,
  output logic ready_pin_oe_n,
  output logic term_pin,
  output logic req_pin,
  output logic aux_bus_grant_in,
  output logic [7:0] modem_status,
  output logic status_irq
);
  logic rst_meta;
  logic rst_sync;
  logic ready_level;
  logic ready_changed;
  logic ready_in_mode;
  logic grant_mode;
  logic next_term_pin;
  logic next_req_pin;
  logic next_ready_out;
  logic next_ready_oe_n;
  logic [7:0] next_status;
  logic next_irq;
  logic det_level;
  logic term_modem_level;
  logic req_modem_level;

  // Reset release through two flip-flops.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'h0;
      rst_sync <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_sync <= rst_meta;
    end
  end

  // Function decode of the shared input pin.
  assign ready_in_mode = (pin_sel.in_sel == mhs_pkg::IN_SEL_READY);
  assign grant_mode = (pin_sel.in_sel == mhs_pkg::IN_SEL_GRANT);

  // RULE1 ready input function.
  // Change detection only sees the pin while it is a ready input; otherwise idle high.
  assign det_level = ready_in_mode ? ready_pin_in : mhs_pkg::PIN_IDLE;

  // Sticky change flag; a status read clears it unless a new change arrives.
  mhs_change_det u_det (
    .mclk(mclk),
    .rst_n(rst_sync),
    .level_in(det_level),
    .read_clr(status_read),
    .last_level(ready_level),
    .changed(ready_changed)
  );

  // RULE1 input pin function.
  // The pin is only driven when it serves as select line seven.
  assign next_ready_oe_n = (pin_sel.in_sel != mhs_pkg::IN_SEL_SELECT7);
  assign next_ready_out = alt_out.select_line_seven_n;

  // Picks the level of a shared output pin from its function select.
  // The unused code falls back to the modem function so the pin always has a defined level.
  function automatic logic route_pin(
    input logic [1:0] sel,
    input logic aux_val,
    input logic select_val,
    input logic modem_val
  );
    logic picked;
    picked = modem_val;
    case (sel)
      mhs_pkg::OUT_SEL_AUX: picked = aux_val;
      mhs_pkg::OUT_SEL_SELECT: picked = select_val;
      default: picked = modem_val;
    endcase
    return picked;
  endfunction : route_pin

  // RULE7 terminal ready low.
  // RULE9 loopback holds high.
  // Loopback parks the modem outputs at their inactive level whatever the control bits say.
  assign term_modem_level = loop_mode ? mhs_pkg::PIN_IDLE : ~ctl_term_ready;

  // RULE10 send request level.
  assign req_modem_level = loop_mode ? mhs_pkg::PIN_IDLE : ~ctl_send_request;

  // RULE6 output pin function.
  assign next_term_pin = route_pin(pin_sel.term_sel, alt_out.shared_mem_drive_ctl,
    alt_out.select_line_eight_n, term_modem_level);

  // RULE10 send request output.
  assign next_req_pin = route_pin(pin_sel.req_sel, alt_out.aux_bus_request_out,
    alt_out.select_line_six_n, req_modem_level);

  // RULE3 complemented ready bit.
  // RULE4 change flag in status.
  always_comb begin
    next_status = 8'h00;
    next_status[mhs_pkg::MSR_READY_BIT] = ~ready_level;
    next_status[mhs_pkg::MSR_DELTA_BIT] = ready_changed;
  end

  // RULE5 change raises interrupt.
  // RULE13 held until read.
  assign next_irq = status_irq_en & ready_changed;

  // Registered outputs; reset leaves every pin at its idle high level.
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      // RULE8 reset forces high.
      term_pin <= mhs_pkg::PIN_IDLE;
      req_pin <= mhs_pkg::PIN_IDLE;
      ready_pin_out <= mhs_pkg::PIN_IDLE;
      ready_pin_oe_n <= 1'h1;
      aux_bus_grant_in <= mhs_pkg::PIN_IDLE;
      modem_status <= 8'h00;
      status_irq <= 1'h0;
    end else begin
      term_pin <= next_term_pin;
      req_pin <= next_req_pin;
      ready_pin_out <= next_ready_out;
      ready_pin_oe_n <= next_ready_oe_n;
      // RULE11 grant from pin.
      aux_bus_grant_in <= grant_mode ? ready_pin_in : mhs_pkg::PIN_IDLE;
      modem_status <= next_status;
      status_irq <= next_irq;
    end
  end

  // RULE7 terminal ready asserted.
  a_term_ctl_low: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE7
    (pin_sel.term_sel == mhs_pkg::OUT_SEL_MODEM && ctl_term_ready && !loop_mode)
    |=> !term_pin) else $error("terminal ready not low");

  // RULE7 terminal ready released.
  a_term_ctl_high: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE7
    (pin_sel.term_sel == mhs_pkg::OUT_SEL_MODEM && !ctl_term_ready)
    |=> term_pin) else $error("terminal ready low without control bit");

  // RULE9 loopback terminal high.
  a_term_loop_high: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE9
    (pin_sel.term_sel == mhs_pkg::OUT_SEL_MODEM && loop_mode) |=> term_pin)
    else $error("terminal ready not held high in loop");

  // RULE10 send request released.
  a_req_loop_high: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE10
    (pin_sel.req_sel == mhs_pkg::OUT_SEL_MODEM && (loop_mode || !ctl_send_request))
    |=> req_pin) else $error("send request not high");

  // RULE10 send request asserted.
  a_req_ctl_low: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE10
    (pin_sel.req_sel == mhs_pkg::OUT_SEL_MODEM && ctl_send_request && !loop_mode)
    |=> !req_pin) else $error("send request not low");

  // RULE6 drive control routed.
  a_term_drive_route: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE6
    (pin_sel.term_sel == mhs_pkg::OUT_SEL_AUX)
    |=> term_pin == $past(alt_out.shared_mem_drive_ctl))
    else $error("drive control not routed");

  // RULE6 select eight routed.
  a_term_select8: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE6
    (pin_sel.term_sel == mhs_pkg::OUT_SEL_SELECT)
    |=> term_pin == $past(alt_out.select_line_eight_n))
    else $error("select eight not routed");

  // RULE1 select seven driven.
  a_sel7_drive: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE1
    (pin_sel.in_sel == mhs_pkg::IN_SEL_SELECT7) |=> !ready_pin_oe_n)
    else $error("select seven not driven");

  // RULE1 select seven value.
  a_sel7_value: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE1
    (pin_sel.in_sel == mhs_pkg::IN_SEL_SELECT7)
    |=> ready_pin_out == $past(alt_out.select_line_seven_n))
    else $error("select seven value not routed");

  // RULE1 pin released as input.
  a_ready_released: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE1
    (pin_sel.in_sel != mhs_pkg::IN_SEL_SELECT7) |=> ready_pin_oe_n)
    else $error("shared input pin driven outside select seven");

  // RULE11 grant follows pin.
  a_grant_follow: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE11
    grant_mode |=> aux_bus_grant_in == $past(ready_pin_in))
    else $error("bus grant does not follow pin");

  // RULE11 grant idle otherwise.
  a_grant_idle: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE11
    !grant_mode |=> aux_bus_grant_in)
    else $error("bus grant active outside grant function");

  // RULE3 complemented ready bit.
  a_ready_bit_inv: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE3
    ready_in_mode ##1 ready_in_mode
    |=> modem_status[mhs_pkg::MSR_READY_BIT] == !$past(ready_pin_in, 2))
    else $error("ready bit not complement");

  // RULE4 change bit shown.
  a_delta_bit: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE4
    ready_changed |=> modem_status[mhs_pkg::MSR_DELTA_BIT])
    else $error("change bit not shown in status");

  // RULE5 change raises interrupt.
  a_irq_on_change: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE5
    (status_irq_en && ready_changed) |=> status_irq) else $error("no interrupt");

  // RULE5 masked interrupt quiet.
  a_irq_masked: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE5
    !status_irq_en |=> !status_irq) else $error("interrupt raised while disabled");

  // RULE13 interrupt held.
  // The interrupt lags the flag by a cycle, so a read one cycle back may still drop it.
  a_irq_holds: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE13
    (status_irq && status_irq_en && !status_read && !$past(status_read)) |=> status_irq)
    else $error("interrupt dropped before read");

  // RULE13 interrupt cleared by read.
  a_irq_clears: assert property (@(posedge mclk) disable iff (!rst_sync) // RULE13
    (status_read && det_level == ready_level) |-> ##2 !status_irq)
    else $error("interrupt kept after read without change");

  // RULE8 reset leaves high.
  a_reset_high: assert property (@(posedge mclk) $rose(rst_sync) |-> term_pin && req_pin) // RULE8
    else $error("pins not high after reset");
endmodule : mhs_top

/* tb/mhs_modem_model.sv */
// Modem model for the shared ready line of the handshake block.
// Assumes the bench changes want_link on the falling edge of mclk.
`timescale 1ns/1ps
module mhs_modem_model (
  input wire logic want_link,
  output logic ready_line
);
  assign ready_line = ~want_link;
endmodule : mhs_modem_model

/* tb/mhs_top_tb.sv */
// Bench for the modem handshake block: pin routing, reset levels and ready status.
// Assumes the modem model file; every input changes on the falling edge of mclk.
`timescale 1ns/1ps
module mhs_top_tb;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  mhs_pkg::mhs_sel_s pin_sel = 6'h2a;
  mhs_pkg::mhs_alt_s alt_out = 5'h00;
  logic ctl_term_ready = 1'h1;
  logic ctl_send_request = 1'h1;
  logic loop_mode = 1'h0;
  logic status_irq_en = 1'h1;
  logic status_read = 1'h0;
  logic want_link = 1'h0;
  logic modem_line, ready_pin_in, ready_pin_out, ready_pin_oe_n, term_pin, req_pin;
  logic aux_bus_grant_in, status_irq;
  logic [7:0] modem_status;
  int err_count = 0;
  int samples_checked = 0;
  // The shared pin follows the block while it drives, else the modem.
  assign ready_pin_in = ready_pin_oe_n ? modem_line : ready_pin_out;
  mhs_modem_model modem (.want_link, .ready_line(modem_line));
  mhs_top dut (.mclk, .rst_n, .pin_sel, .alt_out, .ctl_term_ready, .ctl_send_request,
    .loop_mode, .status_irq_en, .status_read, .ready_pin_in, .ready_pin_out,
    .ready_pin_oe_n, .term_pin, .req_pin, .aux_bus_grant_in, .modem_status, .status_irq);
  initial forever #10 mclk = ~mclk;
  // Compares one value with its expectation and counts the result.
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // Reset holds the modem outputs high although both control bits ask for low.
  task automatic t_reset;
    step(2);
    chk(term_pin, 1'h1);
    chk(req_pin, 1'h1);
    chk({modem_status, status_irq}, 9'h000);
    step(6);
    rst_n = 1'h1;
    step(6);
    chk(term_pin, 1'h0);
    chk(req_pin, 1'h0);
  endtask : t_reset
  // A ready change sets the flag and interrupt; a read clears both.
  task automatic t_ready;
    want_link = 1'h1;
    step(4);
    chk(modem_status, 8'h22);
    chk(status_irq, 1'h1);
    status_read = 1'h1;
    step(1);
    status_read = 1'h0;
    step(4);
    chk({modem_status, status_irq}, 9'h040);
    status_irq_en = 1'h0;
    want_link = 1'h0;
    step(4);
    chk({modem_status, status_irq}, 9'h004);
  endtask : t_ready
  // Both shared output pins follow each of their three functions and loopback.
  task automatic t_term;
    pin_sel.term_sel = mhs_pkg::OUT_SEL_AUX;
    pin_sel.req_sel = mhs_pkg::OUT_SEL_AUX;
    alt_out.shared_mem_drive_ctl = 1'h1;
    alt_out.aux_bus_request_out = 1'h1;
    step(3);
    chk({term_pin, req_pin}, 2'h3);
    // Modem levels go high so the low select lines differ from both other functions.
    pin_sel.term_sel = mhs_pkg::OUT_SEL_SELECT;
    pin_sel.req_sel = mhs_pkg::OUT_SEL_SELECT;
    ctl_term_ready = 1'h0;
    ctl_send_request = 1'h0;
    step(3);
    chk({term_pin, req_pin}, 2'h0);
    pin_sel.term_sel = mhs_pkg::OUT_SEL_MODEM;
    pin_sel.req_sel = mhs_pkg::OUT_SEL_MODEM;
    ctl_term_ready = 1'h1;
    ctl_send_request = 1'h1;
    loop_mode = 1'h1;
    step(3);
    chk({term_pin, req_pin}, 2'h3);
    loop_mode = 1'h0;
    ctl_term_ready = 1'h0;
    step(3);
    chk({term_pin, req_pin}, 2'h2);
  endtask : t_term
  // The shared input serves as bus grant, then as driven select line seven.
  task automatic t_share;
    pin_sel.in_sel = mhs_pkg::IN_SEL_GRANT;
    want_link = 1'h1;
    step(3);
    chk(aux_bus_grant_in, 1'h0);
    pin_sel.in_sel = mhs_pkg::IN_SEL_SELECT7;
    alt_out.select_line_seven_n = 1'h0;
    step(3);
    chk({ready_pin_oe_n, ready_pin_out}, 2'h0);
    chk(aux_bus_grant_in, 1'h1);
  endtask : t_share
  // Cuts a hang short.
  initial begin
    #100000;
    err_count++;
    complete_run;
  end
  initial begin
    t_reset;
    t_ready;
    t_term;
    t_share;
    complete_run;
  end
endmodule : mhs_top_tb
